/* hdl/pmt_top.sv */
module pmt_top
	import pmt_pkg::*;
(
	// Clock and reset.
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	// APB slave.
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [PMT_ADDR_W-1:0] paddr,
	input  wire logic [31:0]           pwdata,
	output logic [31:0]                prdata,
	output logic                       pready,
	output logic                       pslverr,
	// Power state from the core, same clock domain.
	input  wire logic                  sleep_mode,
	// Timer outputs.
	output logic [PMT_NUM_TMR-1:0]     pwm_time_base,
	output logic                       spi_shift_clk,
	output logic                       irq_req
);

	typedef struct packed {
		logic [1:0]                   div;
		logic                         tick;
		pmt_ctrl_s [PMT_NUM_TMR-1:0]  ctrl;
		logic [PMT_NUM_TMR-1:0]       flags;
		logic [PMT_NUM_TMR-1:0]       enables;
		logic [31:0]                  rdata;
		logic                         ready;
		logic                         err;
		logic [PMT_NUM_TMR-1:0]       match;
		logic                         shift;
		logic                         irq;
	} pmt_top_s;

	pmt_top_s                s_reg;
	pmt_top_s                s_next;
	pmt_wr_s                 wr [PMT_NUM_TMR];
	logic [7:0]              cnt [PMT_NUM_TMR];
	logic [7:0]              per [PMT_NUM_TMR];
	logic [5:0]              pre [PMT_NUM_TMR];
	logic [PMT_NUM_TMR-1:0]  match;
	logic [PMT_NUM_TMR-1:0]  term;
	logic                    access;
	pmt_dec_s                dec;

	// Address decode, shared by the read mux and the write strobes.
	function automatic pmt_dec_s pmt_decode(input logic [PMT_ADDR_W-1:0] a);
		pmt_dec_s d;
		d          = '0;
		d.ofs      = {4'h0, a[3:0]};
		d.inst     = a[6:4];
		if (a[1:0] == 2'h0)
		begin
			if (a[7:4] < 4'(PMT_NUM_TMR) && d.ofs != 8'h0C)
			begin
				d.valid    = 1'b1;
				d.is_timer = 1'b1;
			end
			else if (a == PMT_OFS_FLAGS || a == PMT_OFS_ENABLES || a == PMT_OFS_STATUS)
			begin
				d.valid = 1'b1;
				d.ofs   = a;
			end
		end
		return d;
	endfunction

	assign dec    = pmt_decode(paddr);
	assign access = psel && penable && s_reg.ready;

	// Five identical instances with their own strobes and registers.
	for (genvar i = 0; i < PMT_NUM_TMR; i++)
	begin : g_tmr
		logic hit;
		assign hit = access && pwrite && dec.is_timer && dec.inst == 3'(i);
		assign wr[i].wr_count  = hit && dec.ofs == PMT_OFS_COUNT;
		assign wr[i].wr_period = hit && dec.ofs == PMT_OFS_PERIOD;
		assign wr[i].wr_ctrl   = hit && dec.ofs == PMT_OFS_CONTROL;
		assign wr[i].data      = pwdata[7:0];

		pmt_timer u_tmr
		(
			.clk      (clk),
			.rst_n    (rst_n),
			.tick     (s_reg.tick),
			.ctrl     (s_reg.ctrl[i]),
			.wr       (wr[i]),
			.count_o  (cnt[i]),
			.period_o (per[i]),
			.pre_o    (pre[i]),
			.match_o  (match[i]),
			.term_o   (term[i])
		);
	end

	// Bus, clock divider, flags and output staging.
	always_comb
	begin
		s_next = s_reg;
		// The divider keeps running in sleep so phase is kept on wake.
		s_next.div  = s_reg.div + 2'h1;
		s_next.tick = (s_reg.div == PMT_ICLK_LAST) && !sleep_mode;

		// Ready one cycle after setup; read data is captured at setup.
		s_next.ready = psel && !penable;
		s_next.err   = 1'b0;
		if (psel && !penable)
		begin
			s_next.rdata = 32'h0000_0000;
			s_next.err   = !dec.valid;
			if (dec.is_timer)
			begin
				unique case (dec.ofs)
					PMT_OFS_COUNT:   s_next.rdata = {24'h0, cnt[dec.inst]};
					PMT_OFS_PERIOD:  s_next.rdata = {24'h0, per[dec.inst]};
					PMT_OFS_CONTROL: s_next.rdata = {25'h0, s_reg.ctrl[dec.inst]};
					default:         s_next.rdata = 32'h0000_0000;
				endcase
			end
			else if (dec.ofs == PMT_OFS_FLAGS)
				s_next.rdata = {27'h0, s_reg.flags};
			else if (dec.ofs == PMT_OFS_ENABLES)
				s_next.rdata = {27'h0, s_reg.enables};
			else if (dec.ofs == PMT_OFS_STATUS)
				s_next.rdata = {26'h0, s_reg.irq, s_reg.flags & s_reg.enables};
		end

		// Control and enable writes.
		if (access && pwrite && dec.is_timer && dec.ofs == PMT_OFS_CONTROL)
			s_next.ctrl[dec.inst] = pwdata[6:0];
		if (access && pwrite && dec.ofs == PMT_OFS_ENABLES && !dec.is_timer)
			s_next.enables = pwdata[4:0];

		// Writing zero clears a flag, but a new terminal count wins.
		if (access && pwrite && dec.ofs == PMT_OFS_FLAGS && !dec.is_timer)
			s_next.flags = s_reg.flags & pwdata[4:0];
		s_next.flags = s_next.flags | term;

		s_next.match = match;
		s_next.shift = match[0];
		s_next.irq   = |(s_reg.flags & s_reg.enables);
	end

	// State register.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_reg         <= '0;
			s_reg.ctrl    <= {PMT_NUM_TMR{PMT_CONTROL_RST}};
			s_reg.flags   <= PMT_FLAGS_RST;
			s_reg.enables <= PMT_ENABLES_RST;
		end
		else
			s_reg <= s_next;
	end

	// All outputs come straight from the state register.
	assign prdata        = s_reg.rdata;
	assign pready        = s_reg.ready;
	assign pslverr       = s_reg.err;
	assign pwm_time_base = s_reg.match;
	assign spi_shift_clk = s_reg.shift;
	assign irq_req       = s_reg.irq;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_tick_spacing: assert property (s_reg.tick |=> !s_reg.tick [*3])
		else $error("instruction tick closer than four clocks");

	a_sleep_stops: assert property (sleep_mode |=> !s_reg.tick)
		else $error("tick issued during sleep");

	a_flag_sticky: assert property (s_reg.flags[0] && !(access && pwrite
		&& dec.ofs == PMT_OFS_FLAGS && !dec.is_timer) |=> s_reg.flags[0])
		else $error("flag dropped without software clear");

	a_flag_set: assert property (term[2] |=> s_reg.flags[2])
		else $error("terminal count did not set flag");

	a_irq_gate: assert property (s_reg.irq |-> $past(|(s_reg.flags & s_reg.enables)))
		else $error("interrupt request without enabled flag");

	a_pwm_base: assert property (match[3] |=> pwm_time_base[3])
		else $error("match not passed to time base");

	a_shift_first: assert property (spi_shift_clk |-> pwm_time_base[0])
		else $error("shift clock not from first timer");

	a_wr_clears: assert property (wr[1].wr_count |=> pre[1] == 6'h00)
		else $error("count write left prescaler running");

	a_period_reset: assert property ($rose(rst_n) |-> per[4] == 8'hFF && cnt[4] == 8'h00)
		else $error("reset values wrong");

	a_apb_ready: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");

endmodule // pmt_top

/* hdl/pmt_pkg.sv */
package pmt_pkg;

	// Instance count and register geometry.
	localparam int        PMT_NUM_TMR      = 5;
	localparam int        PMT_ADDR_W       = 8;
	localparam logic [7:0] PMT_TMR_STRIDE  = 8'h10;
	localparam logic [7:0] PMT_OFS_COUNT   = 8'h00;
	localparam logic [7:0] PMT_OFS_PERIOD  = 8'h04;
	localparam logic [7:0] PMT_OFS_CONTROL = 8'h08;
	localparam logic [7:0] PMT_OFS_FLAGS   = 8'h50;
	localparam logic [7:0] PMT_OFS_ENABLES = 8'h54;
	localparam logic [7:0] PMT_OFS_STATUS  = 8'h58;

	// Reset values.
	localparam logic [7:0] PMT_COUNT_RST   = 8'h00;
	localparam logic [7:0] PMT_PERIOD_RST  = 8'hFF;
	localparam logic [6:0] PMT_CONTROL_RST = 7'h00;
	localparam logic [4:0] PMT_FLAGS_RST   = 5'h00;
	localparam logic [4:0] PMT_ENABLES_RST = 5'h00;

	// Instruction clock is the system clock divided by four.
	localparam logic [1:0] PMT_ICLK_LAST   = 2'h3;

	// Prescaler terminal values for divide by 1, 4, 16 and 64.
	localparam logic [5:0] PMT_PRE_DIV1    = 6'h00;
	localparam logic [5:0] PMT_PRE_DIV4    = 6'h03;
	localparam logic [5:0] PMT_PRE_DIV16   = 6'h0F;
	localparam logic [5:0] PMT_PRE_DIV64   = 6'h3F;

	// Control register layout: postscale 6:3, timer on 2, prescale 1:0.
	typedef struct packed {
		logic [3:0] postscale_select;
		logic       timer_on;
		logic [1:0] prescale_select;
	} pmt_ctrl_s;

	// Register write strobes towards one timer instance.
	typedef struct packed {
		logic       wr_count;
		logic       wr_period;
		logic       wr_ctrl;
		logic [7:0] data;
	} pmt_wr_s;

	// Decoded APB address.
	typedef struct packed {
		logic       valid;
		logic       is_timer;
		logic [2:0] inst;
		logic [7:0] ofs;
	} pmt_dec_s;

	function automatic logic [5:0] pmt_pre_limit(input logic [1:0] sel);
		unique case (sel)
			2'h0: pmt_pre_limit = PMT_PRE_DIV1;
			2'h1: pmt_pre_limit = PMT_PRE_DIV4;
			2'h2: pmt_pre_limit = PMT_PRE_DIV16;
			2'h3: pmt_pre_limit = PMT_PRE_DIV64;
		endcase
	endfunction

endpackage

/* hdl/pmt_timer.sv */
module pmt_timer
	import pmt_pkg::*;
(
	// Clock and reset.
	input  wire logic      clk,
	input  wire logic      rst_n,
	// Timing and configuration.
	input  wire logic      tick,
	input  wire pmt_ctrl_s ctrl,
	input  wire pmt_wr_s   wr,
	// State and events.
	output logic [7:0]     count_o,
	output logic [7:0]     period_o,
	output logic [5:0]     pre_o,
	output logic           match_o,
	output logic           term_o
);

	typedef struct packed {
		logic [7:0] count;
		logic [7:0] period;
		logic [5:0] pre;
		logic [3:0] post;
		logic       match;
		logic       term;
	} pmt_tmr_s;

	pmt_tmr_s s_reg;
	pmt_tmr_s s_next;

	// Counting path; software writes come last so they win over a tick.
	always_comb
	begin
		s_next       = s_reg;
		s_next.match = 1'b0;
		s_next.term  = 1'b0;
		if (tick && ctrl.timer_on)
		begin
			if (s_reg.pre >= pmt_pre_limit(ctrl.prescale_select))
			begin
				s_next.pre = 6'h00;
				if (s_reg.count == s_reg.period)
				begin
					s_next.count = PMT_COUNT_RST;
					s_next.match = 1'b1;
					// Compare with >= so a lowered ratio never runs past sixteen.
					if (s_reg.post >= ctrl.postscale_select)
					begin
						s_next.post = 4'h0;
						s_next.term = 1'b1;
					end
					else
						s_next.post = s_reg.post + 4'h1;
				end
				else
					s_next.count = s_reg.count + 8'h01;
			end
			else
				s_next.pre = s_reg.pre + 6'h01;
		end
		if (wr.wr_ctrl)
		begin
			s_next.pre  = 6'h00;
			s_next.post = 4'h0;
		end
		if (wr.wr_count)
		begin
			s_next.count = wr.data;
			s_next.pre   = 6'h00;
			s_next.post  = 4'h0;
		end
		if (wr.wr_period)
			s_next.period = wr.data;
	end

	// State register; every reset source reaches here through rst_n.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_reg <= '{PMT_COUNT_RST, PMT_PERIOD_RST, 6'h00, 4'h0, 1'b0, 1'b0};
		else
			s_reg <= s_next;
	end

	assign count_o  = s_reg.count;
	assign period_o = s_reg.period;
	assign pre_o    = s_reg.pre;
	assign match_o  = s_reg.match;
	assign term_o   = s_reg.term;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_match_reload: assert property (s_reg.match && !$past(wr.wr_count) |-> s_reg.count == 8'h00)
		else $error("count not reloaded to zero on match");

	a_count_step: assert property (tick && ctrl.timer_on && !wr.wr_count && !wr.wr_ctrl
		&& s_reg.pre >= pmt_pre_limit(ctrl.prescale_select) && s_reg.count != s_reg.period
		|=> s_reg.count == $past(s_reg.count) + 8'h01)
		else $error("count did not advance by one");

	a_ctrl_keeps: assert property (wr.wr_ctrl && !wr.wr_count && !tick
		|=> s_reg.count == $past(s_reg.count) && s_reg.pre == 6'h00 && s_reg.post == 4'h0)
		else $error("control write disturbed count or scalers");

	a_match_cause: assert property (s_reg.match |-> $past(tick && ctrl.timer_on
		&& s_reg.count == s_reg.period))
		else $error("match without equal compare");

	a_term_ratio: assert property (s_reg.term |-> s_reg.match
		&& $past(s_reg.post) >= $past(ctrl.postscale_select))
		else $error("postscaler terminal at wrong count");

	a_off_holds: assert property (!ctrl.timer_on && !wr.wr_count
		|=> s_reg.count == $past(s_reg.count) && !s_reg.match)
		else $error("timer moved while off");

endmodule // pmt_timer

/* sim/pmt_top_tb_top.sv */
module pmt_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pmt_pkg::*;

	logic                  clk;
	logic                  rst_n;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [PMT_ADDR_W-1:0] paddr;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic                  pready;
	logic                  pslverr;
	logic                  sleep_mode;
	logic [PMT_NUM_TMR-1:0] pwm_time_base;
	logic                  spi_shift_clk;
	logic                  irq_req;
	int                    failures;
	int                    n_tests;
	logic                  last_err;
	logic [31:0]           q;
	logic [31:0]           q2;
	int                    n;
	// Postscale codes tried: the shortest, a middle one and the longest ratio.
	int                    codes [3] = '{0, 5, 15};

	pmt_top u_pmt_top (
		.clk           (clk),
		.rst_n         (rst_n),
		.psel          (psel),
		.penable       (penable),
		.pwrite        (pwrite),
		.paddr         (paddr),
		.pwdata        (pwdata),
		.prdata        (prdata),
		.pready        (pready),
		.pslverr       (pslverr),
		.sleep_mode    (sleep_mode),
		.pwm_time_base (pwm_time_base),
		.spi_shift_clk (spi_shift_clk),
		.irq_req       (irq_req)
	);

	// A 4 ns clock.
	always #2 clk = ~clk;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask

	// One APB transfer; the request is held until pready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge clk);
			k++;
		end
		while (pready !== 1'b1 && k < 20);
		if (k >= 20)
		begin
			failures++;
			wrap_up();
		end
		q        = prdata;
		last_err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
		apb(1'b0, a, 32'h0);
		chk(q, exp, msg);
	endtask

	// Measures clocks between two match pulses of one timer; a lost pulse is a mismatch.
	task automatic gap(input int i, output int g);
		int k;
		k = 0;
		while (pwm_time_base[i] !== 1'b1 && k < 3000)
		begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		g = 1;
		while (pwm_time_base[i] !== 1'b1 && g < 3000)
		begin
			@(negedge clk);
			g++;
		end
	endtask

	// The serial shift clock must mirror the first timer's match pulse.
	always @(negedge clk)
		if (rst_n && (spi_shift_clk | pwm_time_base[0]))
			chk({31'h0, spi_shift_clk}, {31'h0, pwm_time_base[0]}, "spi clk");

	// A hang is cut short and counted.
	initial
	begin
		repeat (100000) @(posedge clk);
		failures++;
		wrap_up();
	end

	// Main sequence.
	initial
	begin
		clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
		paddr = 8'h00; pwdata = 32'h0; sleep_mode = 0; failures = 0; n_tests = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < PMT_NUM_TMR; i++)
		begin
			rd(8'(i * 16), 32'h0000_0000, "count reset");
			rd(8'(i * 16 + 4), 32'h0000_00FF, "period reset");
			rd(8'(i * 16 + 8), 32'h0000_0000, "ctrl reset");
			wr(8'(i * 16 + 4), 32'hFFFF_FF10 + i);
			wr(8'(i * 16), 32'hFFFF_FF20 + i);
			rd(8'(i * 16 + 4), 32'h10 + i, "period rw");
			rd(8'(i * 16), 32'h20 + i, "count rw");
		end
		rd(8'h50, 32'h0, "flags reset");
		rd(8'h54, 32'h0, "enables reset");
		rd(8'h5C, 32'h0, "unmapped read");
		chk({31'h0, last_err}, 32'h1, "unmapped err");
		wr(8'h02, 32'h55);
		chk({31'h0, last_err}, 32'h1, "unaligned err");
		// A control write keeps the count, and a stopped timer holds it.
		wr(8'h00, 32'h37);
		wr(8'h08, 32'h78);
		repeat (60) @(posedge clk);
		rd(8'h00, 32'h37, "count after ctrl");
		rd(8'h08, 32'h78, "ctrl rw");
		// Sleep freezes a running timer; waking resumes it.
		wr(8'h04, 32'hFF);
		sleep_mode <= 1'b1;
		wr(8'h08, 32'h04);
		apb(1'b0, 8'h00, 32'h0);
		repeat (60) @(posedge clk);
		rd(8'h00, q, "sleep hold");
		q2 = q;
		sleep_mode <= 1'b0;
		repeat (60) @(posedge clk);
		apb(1'b0, 8'h00, 32'h0);
		chk({31'h0, q > q2}, 32'h1, "count advances");
		// Match interval per prescale code, one code per timer.
		for (int p = 0; p < 4; p++)
		begin
			wr(8'((p + 1) * 16 + 4), 32'h3);
			wr(8'((p + 1) * 16), 32'h0);
			wr(8'((p + 1) * 16 + 8), 32'h4 | p);
			gap(p + 1, n);
			chk(n, 16 * (1 << (2 * p)), "match interval");
			wr(8'((p + 1) * 16 + 8), 32'h0);
		end
		// Matches per flag for several postscale codes, with the flag latched.
		wr(8'h04, 32'h2);
		wr(8'h54, 32'h1);
		foreach (codes[j])
		begin
			wr(8'h08, 32'h0);
			wr(8'h00, 32'h0);
			wr(8'h50, 32'h0);
			// The request trails the flag register by one cycle.
			repeat (2) @(posedge clk);
			chk({31'h0, irq_req}, 32'h0, "irq cleared");
			wr(8'h08, 32'h4 | (codes[j] << 3));
			n = 0;
			for (int k = 0; k < 400 && irq_req !== 1'b1; k++)
			begin
				@(negedge clk);
				if (pwm_time_base[0] === 1'b1)
					n++;
			end
			chk(n, codes[j] + 1, "matches per flag");
			repeat (200) @(posedge clk);
			rd(8'h50, 32'h1, "flag held");
		end
		// Without the enable the flag still sets but no request follows.
		wr(8'h54, 32'h0);
		wr(8'h08, 32'h04);
		wr(8'h50, 32'h0);
		repeat (40) @(posedge clk);
		rd(8'h50, 32'h1, "flag no enable");
		chk({31'h0, irq_req}, 32'h0, "irq masked");
		wrap_up();
	end
endmodule // pmt_top_tb_top
